// >>> verilog/eaa_pkg.sv
// Notes on behaviour
// - A 22-bit secondary space exists beside the 256 primary registers.
// - Configuration register 0x09 sets the high secondary address bits.
// - Pointer register 0x0A gives the low 16 secondary address bits.
// - Port 0x0B reads the next 16 field bits, or writes 16 bits.
// - Reading a long-object register, or a user-object write of non-zero length up to the maximum, loads configuration and pointer automatically.
// - Long-object read answers auto-indirect status, byte length, pointer set up.
// - Port read past the field end answers execution error, zero data.
// - Zero-length user-object write: no setup, OK status, maximum byte count.
// - Non-zero-length write up to the maximum: setup, record length, auto-indirect status.
// - Successive port writes store words into consecutive field positions.
// - Port write during background store answers pending, held until done.
// - After a finished store the status register reads OK with zero.
// - Field bytes are big-endian: first byte in the upper half.
// - Invalid secondary address gives reason 0x06, read-only gives 0x07.
`default_nettype none
package eaa_pkg;
  // ----------------------------------------
  // Primary register offsets
  // ----------------------------------------
  localparam logic [7:0] REG_NOP = 8'h00;
  localparam logic [7:0] REG_DEV_KIND = 8'h01;
  localparam logic [7:0] REG_CFG = 8'h09;
  localparam logic [7:0] REG_PTR = 8'h0A;
  localparam logic [7:0] REG_PORT = 8'h0B;
  localparam logic [7:0] REG_USER = 8'hFF;
  // ----------------------------------------
  // Secondary space layout
  // ----------------------------------------
  localparam int SEC_ADDR_W = 22;
  localparam int CFG_HIGH_W = SEC_ADDR_W - 16;
  localparam logic [5:0] REGION_DEV_KIND = 6'h01;
  localparam logic [5:0] REGION_USER = 6'h02;
  localparam logic [15:0] DEV_KIND_LEN = 16'h0006;
  localparam logic [15:0] USER_MAX_LEN = 16'h0020;
  // Arbitrary identity text, not a real part code
  localparam logic [47:0] DEV_KIND_TEXT = 48'h4142_4344_0000;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] LEN_RST = 16'h0000;
  localparam int NOP_PEND_BIT = 8;
  // ----------------------------------------
  // Error reason codes
  // ----------------------------------------
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_RNI = 4'h1;
  localparam logic [3:0] ERR_RNW = 4'h2;
  localparam logic [3:0] ERR_RVE = 4'h3;
  localparam logic [3:0] ERR_RANGE = 4'h6;
  localparam logic [3:0] ERR_RO = 4'h7;
  // ----------------------------------------
  // Timing and buffering
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int STORE_NS = 200;
  localparam logic [7:0] STORE_CYCLES = 8'((STORE_NS + CLK_NS - 1) / CLK_NS);
  localparam int FIFO_DEPTH = 8;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_OK = 2'h0,
    ST_XE = 2'h1,
    ST_AEA = 2'h2,
    ST_CP = 2'h3
  } eaa_status_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_SETTLE = 2'b11
  } eaa_state_e;
  typedef struct packed {
    logic write;
    logic [7:0] regn;
    logic [15:0] data;
  } eaa_cmd_s;
  typedef struct packed {
    eaa_status_e status;
    logic [7:0] regn;
    logic [15:0] data;
  } eaa_rsp_s;
  typedef struct packed {
    logic [4:0] idx;
    logic [15:0] word;
  } eaa_store_s;
endpackage
`default_nettype wire

// >>> verilog/eaa_top.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Store buffer
// ----------------------------------------
module eaa_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_out = cnt_r != (AW+1)'(DEPTH);
  assign out_valid_out = cnt_r != '0;
  assign out_data_out = mem[rd_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_r] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= AW'(wr_r + 1'b1);
      end
      if (pop) begin
        rd_r <= AW'(rd_r + 1'b1);
      end
      cnt_r <= (AW+1)'(cnt_r + push - pop);
    end
  end
endmodule

// ----------------------------------------
// Indirect field access unit
// ----------------------------------------
module eaa_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command from packet decoder
  input wire logic cmd_valid_in,
  input wire eaa_pkg::eaa_cmd_s cmd_in,
  output logic cmd_ready_out,
  // Response to packet encoder
  output logic rsp_valid_out,
  output eaa_pkg::eaa_rsp_s rsp_out,
  // Status
  output logic pending_out
);
  import eaa_pkg::*;

  eaa_state_e state_r;
  eaa_cmd_s cmd_r;
  eaa_rsp_s rsp_r;
  eaa_rsp_s rsp_nxt;
  logic ready_r;
  logic rsp_valid_r;
  logic pending_r;
  logic [15:0] cfg_r;
  logic [15:0] cfg_nxt;
  logic [15:0] ptr_r;
  logic [15:0] ptr_nxt;
  logic [15:0] len_r;
  logic [15:0] len_nxt;
  logic [3:0] err_r;
  logic [3:0] err_code;
  logic err_set;
  logic nop_clr;
  logic push;
  logic [7:0] store_cnt_r;
  logic [7:0] user_mem [32];
  logic [47:0] text_shift;
  logic [15:0] size;
  logic [15:0] ptr_step;
  logic fifo_in_ready;
  logic fifo_out_valid;
  eaa_store_s fifo_out;
  eaa_store_s fifo_in;
  logic accept;
  logic store_busy;

  function automatic logic [15:0] region_size(input logic [5:0] region);
    case (region)
      REGION_DEV_KIND: region_size = DEV_KIND_LEN;
      REGION_USER: region_size = USER_MAX_LEN;
      default: region_size = 16'h0000;
    endcase
  endfunction

  assign accept = cmd_valid_in && ready_r && state_r == S_IDLE;
  assign size = region_size(cfg_r[CFG_HIGH_W-1:0]);
  assign ptr_step = (ptr_r + 16'h0002 >= size) ? size : 16'(ptr_r + 16'h0002);
  assign text_shift = DEV_KIND_TEXT << {ptr_r[2:0], 3'b000};
  assign store_busy = fifo_out_valid || store_cnt_r != 8'h00;
  assign fifo_in = '{idx: ptr_r[4:0], word: cmd_r.data};

  // ----------------------------------------
  // Command sequencing
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= S_IDLE;
      ready_r <= 1'b0;
      cmd_r <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          ready_r <= fifo_in_ready && !accept;
          if (accept) begin
            cmd_r <= cmd_in;
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          ready_r <= 1'b0;
          state_r <= S_SETTLE;
        end
        S_SETTLE: begin
          ready_r <= fifo_in_ready;
          state_r <= S_IDLE;
        end
        default: begin
          ready_r <= 1'b0;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Command decode and answer
  // ----------------------------------------
  always_comb begin
    rsp_nxt = '{status: ST_OK, regn: cmd_r.regn, data: 16'h0000};
    cfg_nxt = cfg_r;
    ptr_nxt = ptr_r;
    len_nxt = len_r;
    err_code = ERR_NONE;
    nop_clr = 1'b0;
    push = 1'b0;
    if (state_r == S_EXEC) begin
      case (cmd_r.regn)
        REG_NOP: begin
          if (!cmd_r.write) begin
            rsp_nxt.data = 16'h0000;
            rsp_nxt.data[NOP_PEND_BIT] = pending_r;
            rsp_nxt.data[3:0] = err_r;
            nop_clr = 1'b1;
          end
        end
        REG_DEV_KIND: begin
          if (cmd_r.write) begin
            err_code = ERR_RNW;
          end else begin
            rsp_nxt.status = ST_AEA;
            rsp_nxt.data = DEV_KIND_LEN;
            cfg_nxt = {10'h000, REGION_DEV_KIND};
            ptr_nxt = PTR_RST;
          end
        end
        REG_USER: begin
          if (!cmd_r.write) begin
            rsp_nxt.status = ST_AEA;
            rsp_nxt.data = len_r;
            cfg_nxt = {10'h000, REGION_USER};
            ptr_nxt = PTR_RST;
          end else if (cmd_r.data == 16'h0000) begin
            rsp_nxt.data = USER_MAX_LEN;
          end else if (cmd_r.data > USER_MAX_LEN) begin
            err_code = ERR_RVE;
          end else begin
            rsp_nxt.status = ST_AEA;
            rsp_nxt.data = cmd_r.data;
            cfg_nxt = {10'h000, REGION_USER};
            ptr_nxt = PTR_RST;
            len_nxt = cmd_r.data;
          end
        end
        REG_CFG: begin
          if (cmd_r.write) begin
            cfg_nxt = cmd_r.data;
          end
          rsp_nxt.data = cmd_r.write ? cmd_r.data : cfg_r;
        end
        REG_PTR: begin
          if (cmd_r.write) begin
            ptr_nxt = cmd_r.data;
          end
          rsp_nxt.data = cmd_r.write ? cmd_r.data : ptr_r;
        end
        REG_PORT: begin
          if (size == 16'h0000 || ptr_r >= size) begin
            err_code = ERR_RANGE;
          end else if (cmd_r.write && cfg_r[CFG_HIGH_W-1:0] != REGION_USER) begin
            err_code = ERR_RO;
          end else if (cmd_r.write) begin
            push = 1'b1;
            ptr_nxt = ptr_step;
            rsp_nxt.status = store_busy ? ST_CP : ST_OK;
            rsp_nxt.data = store_busy ? cmd_r.data : 16'h0000;
          end else begin
            ptr_nxt = ptr_step;
            if (cfg_r[CFG_HIGH_W-1:0] == REGION_DEV_KIND) begin
              rsp_nxt.data = text_shift[47:32];
            end else begin
              rsp_nxt.data = {user_mem[ptr_r[4:0]], user_mem[5'(ptr_r[4:0] + 5'h01)]};
            end
          end
        end
        default: begin
          err_code = ERR_RNI;
        end
      endcase
      if (err_code != ERR_NONE) begin
        rsp_nxt.status = ST_XE;
        rsp_nxt.data = 16'h0000;
      end
    end
  end
  assign err_set = err_code != ERR_NONE;

  // ----------------------------------------
  // Indirect registers and answer
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r <= CFG_RST;
      ptr_r <= PTR_RST;
      len_r <= LEN_RST;
      rsp_r <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ptr_r <= ptr_nxt;
      len_r <= len_nxt;
      rsp_valid_r <= state_r == S_EXEC;
      if (state_r == S_EXEC) begin
        rsp_r <= rsp_nxt;
      end
    end
  end

  // ----------------------------------------
  // Error reason and pending flag
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_r <= ERR_NONE;
      pending_r <= 1'b0;
    end else begin
      if (err_set) begin
        err_r <= err_code;
      end else if (nop_clr) begin
        err_r <= ERR_NONE;
      end
      if (push) begin
        pending_r <= 1'b1;
      end else if (!store_busy && state_r != S_SETTLE) begin
        pending_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Background store engine
  // ----------------------------------------
  eaa_fifo #(
    .WIDTH($bits(eaa_store_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(store_cnt_r == 8'h00),
    .out_data_out(fifo_out)
  );

  always_ff @(posedge clk_in) begin
    if (fifo_out_valid && store_cnt_r == 8'h00) begin
      user_mem[fifo_out.idx] <= fifo_out.word[15:8];
      user_mem[5'(fifo_out.idx + 5'h01)] <= fifo_out.word[7:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      store_cnt_r <= 8'h00;
    end else if (fifo_out_valid && store_cnt_r == 8'h00) begin
      store_cnt_r <= STORE_CYCLES;
    end else if (store_cnt_r != 8'h00) begin
      store_cnt_r <= 8'(store_cnt_r - 8'h01);
    end
  end

  assign cmd_ready_out = ready_r;
  assign rsp_valid_out = rsp_valid_r;
  assign rsp_out = rsp_r;
  assign pending_out = pending_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_answer_timing: assert property (accept |-> !rsp_valid_r ##1 !rsp_valid_r ##1 rsp_valid_r
    ##1 !rsp_valid_r)
    else $error("answer not two cycles after accept");
  a_kind_read_setup: assert property (state_r == S_EXEC && !cmd_r.write
    && cmd_r.regn == REG_DEV_KIND |=> rsp_r.status == ST_AEA && rsp_r.data == 16'h0006
    && cfg_r[5:0] == REGION_DEV_KIND && ptr_r == 16'h0000)
    else $error("long-object read setup wrong");
  a_past_end_read: assert property (state_r == S_EXEC && cmd_r.regn == REG_PORT
    && !cmd_r.write && ptr_r >= size |=> rsp_r.status == ST_XE && rsp_r.data == 16'h0000)
    else $error("read past end not refused");
  a_zero_len_write: assert property (state_r == S_EXEC && cmd_r.write
    && cmd_r.regn == REG_USER && cmd_r.data == 16'h0000
    |=> rsp_r.status == ST_OK && rsp_r.data == 16'h0020 && $stable(cfg_r))
    else $error("zero-length write answer wrong");
  a_setup_write: assert property (state_r == S_EXEC && cmd_r.write
    && cmd_r.regn == REG_USER && cmd_r.data != 16'h0000 && cmd_r.data <= 16'h0020
    |=> rsp_r.status == ST_AEA && len_r == $past(cmd_r.data) && cfg_r[5:0] == REGION_USER)
    else $error("setup write not recorded");
  a_ptr_advance: assert property (state_r == S_EXEC && cmd_r.regn == REG_PORT
    && ptr_r < size && (!cmd_r.write || cfg_r[5:0] == REGION_USER)
    |=> ptr_r == $past(ptr_step) && ptr_r <= $past(size)
    && ptr_r != $past(ptr_r))
    else $error("pointer did not step by two");
  a_pending_hold: assert property (push |=> pending_r [*2])
    else $error("pending dropped during store");
  a_store_finish: assert property (push && !store_busy |-> ##[1:500] !pending_r)
    else $error("store did not complete in time");
  a_nop_clean: assert property (state_r == S_EXEC && cmd_r.regn == REG_NOP
    && !cmd_r.write && !pending_r && err_r == ERR_NONE
    |=> rsp_r.status == ST_OK && rsp_r.data == 16'h0000)
    else $error("idle status read not clean");
  a_ro_reason: assert property (state_r == S_EXEC && cmd_r.regn == REG_PORT
    && cmd_r.write && cfg_r[5:0] == REGION_DEV_KIND && ptr_r < size |=> err_r == 4'h7)
    else $error("read-only reason missing");

  c_kind_read: cover property (rsp_valid_r && rsp_r.status == ST_AEA && rsp_r.regn == REG_DEV_KIND);
  c_past_end: cover property (rsp_valid_r && rsp_r.status == ST_XE && rsp_r.regn == REG_PORT);
  c_pending_write: cover property (rsp_valid_r && rsp_r.status == ST_CP);
  c_fifo_full: cover property (!fifo_in_ready);
endmodule
`default_nettype wire

// >>> verification/eaa_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Host issuing one command at a time
// ----------------------------------------
module eaa_host_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bench request
  input wire logic go_in,
  input wire eaa_pkg::eaa_cmd_s req_in,
  output logic done_out,
  output eaa_pkg::eaa_rsp_s got_out,
  // Unit side
  output logic cmd_valid_out,
  output eaa_pkg::eaa_cmd_s cmd_out,
  input wire logic cmd_ready_in,
  input wire logic rsp_valid_in,
  input wire eaa_pkg::eaa_rsp_s rsp_in
);
  import eaa_pkg::*;
  logic wait_r;
  // Hold command until taken, then scramble the idle bus
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_out <= '0;
      wait_r <= 1'b0;
      done_out <= 1'b0;
      got_out <= '0;
    end else begin
      done_out <= 1'b0;
      if (go_in) begin
        cmd_valid_out <= 1'b1;
        cmd_out <= req_in;
      end else if (cmd_valid_out && cmd_ready_in) begin
        cmd_valid_out <= 1'b0;
        cmd_out <= ~cmd_out;
        wait_r <= 1'b1;
      end
      if (wait_r && rsp_valid_in) begin
        got_out <= rsp_in;
        done_out <= 1'b1;
        wait_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import eaa_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic go = 1'b0;
  eaa_cmd_s req = '0;
  logic done, cmd_valid, cmd_ready, rsp_valid, pending;
  eaa_cmd_s cmd;
  eaa_rsp_s rsp, got;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int stalls = 0;
  logic [15:0] words [16];
  logic [3:0] etab [3][4];
  always #5 clk_in = ~clk_in;
  eaa_host_model host (.clk_in(clk_in), .rst_in(rst_in), .go_in(go), .req_in(req),
    .done_out(done), .got_out(got), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
    .cmd_ready_in(cmd_ready), .rsp_valid_in(rsp_valid), .rsp_in(rsp));
  eaa_top dut (.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
    .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid), .rsp_out(rsp),
    .pending_out(pending));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  function automatic logic [15:0] kind_word(input int i);
    return DEV_KIND_TEXT[47-16*i -: 16];
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] r, input logic [15:0] d,
                      input logic [1:0] es, input logic [15:0] ed);
    int n;
    @(posedge clk_in);
    go <= 1'b1;
    req <= '{write: w, regn: r, data: d};
    @(posedge clk_in);
    go <= 1'b0;
    for (n = 0; n < 500 && done !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    if (done !== 1'b1) begin
      failures++;
      $display("[ERR] done expected 1 seen %b", done);
      wrap_up();
    end else begin
      chk("status", {14'h0, es}, {14'h0, got.status});
      chk("regn", {8'h0, r}, {8'h0, got.regn});
      chk("data", ed, got.data);
    end
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cmd_valid && !cmd_ready && !rst_in) begin
      stalls <= stalls + 1;
    end
    if (cycles > 20000) begin
      failures++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(89));
    etab = '{'{4'h0, 4'h5, 4'h5, 4'h1}, '{4'h1, 4'h0, 4'h1, 4'h2}, '{4'h1, 4'hF, 4'hF, 4'h3}};
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    chk("pending", 16'h0, {15'h0, pending});
    xfer(1'b0, REG_CFG, 16'h0, ST_OK, 16'h0000);
    xfer(1'b0, REG_PTR, 16'h0, ST_OK, 16'h0000);
    $display("reset values done");
    xfer(1'b0, REG_DEV_KIND, 16'h0, ST_AEA, DEV_KIND_LEN);
    xfer(1'b0, REG_CFG, 16'h0, ST_OK, {10'h0, REGION_DEV_KIND});
    xfer(1'b0, REG_PTR, 16'h0, ST_OK, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, REG_PORT, 16'h0, ST_OK, kind_word(i));
    end
    xfer(1'b0, REG_PORT, 16'h0, ST_XE, 16'h0000);
    xfer(1'b0, REG_NOP, 16'h0, ST_OK, {12'h0, ERR_RANGE});
    xfer(1'b0, REG_NOP, 16'h0, ST_OK, 16'h0000);
    xfer(1'b1, REG_PTR, 16'h0000, ST_OK, 16'h0000);
    xfer(1'b1, REG_PORT, 16'hA5A5, ST_XE, 16'h0000);
    xfer(1'b0, REG_NOP, 16'h0, ST_OK, {12'h0, ERR_RO});
    $display("read example done");
    for (int i = 0; i < 3; i++) begin
      xfer(etab[i][0], {etab[i][1], etab[i][2]}, {12'h0, etab[i][2]} + 16'h0012, ST_XE, 16'h0);
      xfer(1'b0, REG_NOP, 16'h0, ST_OK, {12'h0, etab[i][3]});
    end
    xfer(1'b1, REG_CFG, 16'h0003, ST_OK, 16'h0003);
    xfer(1'b0, REG_PORT, 16'h0, ST_XE, 16'h0000);
    xfer(1'b0, REG_NOP, 16'h0, ST_OK, {12'h0, ERR_RANGE});
    $display("error codes done");
    xfer(1'b1, REG_USER, 16'h0000, ST_OK, USER_MAX_LEN);
    xfer(1'b1, REG_USER, USER_MAX_LEN, ST_AEA, USER_MAX_LEN);
    chk("pending", 16'h0, {15'h0, pending});
    xfer(1'b0, REG_CFG, 16'h0, ST_OK, {10'h0, REGION_USER});
    xfer(1'b0, REG_PTR, 16'h0, ST_OK, 16'h0000);
    xfer(1'b0, REG_USER, 16'h0, ST_AEA, USER_MAX_LEN);
    foreach (words[i]) begin
      words[i] = 16'($urandom());
    end
    words[0] = 16'h0102;
    xfer(1'b1, REG_PORT, words[0], ST_OK, 16'h0000);
    chk("pending", 16'h1, {15'h0, pending});
    for (int i = 1; i < 16; i++) begin
      xfer(1'b1, REG_PORT, words[i], ST_CP, words[i]);
    end
    chk("stalled", 16'h1, {15'h0, stalls > 0});
    for (int n = 0; n < 1000 && pending !== 1'b0; n++) begin
      @(posedge clk_in);
    end
    chk("pending", 16'h0, {15'h0, pending});
    xfer(1'b0, REG_NOP, 16'h0, ST_OK, 16'h0000);
    $display("write example done");
    xfer(1'b1, REG_PTR, 16'h0000, ST_OK, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b0, REG_PORT, 16'h0, ST_OK, words[i]);
    end
    xfer(1'b0, REG_PORT, 16'h0, ST_XE, 16'h0000);
    xfer(1'b1, REG_PORT, 16'h1234, ST_XE, 16'h0000);
    xfer(1'b0, REG_NOP, 16'h0, ST_OK, {12'h0, ERR_RANGE});
    $display("readback done");
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    xfer(1'b0, REG_CFG, 16'h0, ST_OK, 16'h0000);
    $display("second reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
